// *** src/pis_pkg.sv ***
// package: register map, field positions and types of the interrupt status block
package pis_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // documented status registers
  localparam logic [15:0] PEND_LOW_ADDR = 16'hFE04;
  localparam logic [15:0] PEND_HIGH_ADDR = 16'hFE05;
  // source control and status registers
  localparam logic [15:0] TICK_CTRL_ADDR = 16'hFE20;
  localparam logic [15:0] WRAP_CTRL_ADDR = 16'hFE21;
  localparam logic [15:0] CH0_CTRL_ADDR = 16'hFE22;
  localparam logic [15:0] CH1_CTRL_ADDR = 16'hFE23;
  localparam logic [15:0] DISP_STAT_ADDR = 16'hFE24;
  localparam logic [15:0] DISP_EN_ADDR = 16'hFE25;
  localparam logic [15:0] DISP_LINE_ADDR = 16'hFE26;
  localparam logic [15:0] CAP_STAT_ADDR = 16'hFE27;
  localparam logic [15:0] CAP_CTRL_ADDR = 16'hFE28;
  localparam logic [15:0] CAP_CHAR1_ADDR = 16'hFE29;
  localparam logic [15:0] CAP_CHAR2_ADDR = 16'hFE2A;
  localparam logic [15:0] SER_STAT_ADDR = 16'hFE2B;
  localparam logic [15:0] SER_CTRL_ADDR = 16'hFE2C;
  localparam logic [15:0] SER_DATA_ADDR = 16'hFE2D;
  localparam logic [15:0] EVT_STAT_ADDR = 16'hFE30;
  localparam logic [15:0] EVT_MASK_ADDR = 16'hFE31;
  // field positions
  localparam int TICK_EN_BIT = 0;
  localparam int TICK_ACK_BIT = 1;
  localparam int TICK_RATE_LSB = 2;
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int LINE_BIT = 0;
  localparam int SYNC_BIT = 1;
  localparam int SER_IRQ_EN_BIT = 0;
  localparam int SER_ON_BIT = 1;
  localparam int PEND_LOW_LSB = 2;
  localparam int CAP_BITS = 16;
  localparam int NUM_SLOTS = 9;
  // sticky event bits: tick, wrap, ch0, ch1, line, sync, caption, serial
  localparam int NUM_EVT = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // default tick period exponent: 2^(base+rate) clocks
  localparam int TICK_BASE_LOG2 = 8;
  localparam int TICK_W = 24;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pis_bus_req_t;

  typedef struct packed {
    logic ext_flag;
    logic ext_irq_enable;
    logic pll_flag;
    logic pll_irq_enable;
    logic [15:0] counter_value;
    logic [15:0] counter_modulo;
    logic [1:0] channel_event;
    logic [7:0] scan_line;
    logic frame_sync;
    logic caption_bit_valid;
    logic caption_bit;
    logic transfer_done;
    logic [7:0] serial_rx_data;
  } pis_src_t;
endpackage

// *** src/pis_top.sv ***
// interrupt status block: source flags, enables, acknowledges, pending registers
// Behaviour
// (R1) timebase chain wrap sets tick flag; requests only while tick enable set
// (R2) writing one to tick acknowledge clears the tick flag
// (R3) timer wrap flag sets when counter passes modulo value back to zero
// (R4) wrap requests only with its enable; flag and enable share one register
// (R5) capture or compare sets channel flag; requests only with channel enable
// (R6) scan line equal to target line sets line flag; gated by its enable
// (R7) leading edge of frame sync sets sync flag; gated by its enable
// (R8) any write to display status register acknowledges display flags
// (R9) sixteen caption bits captured into two chars set caption flag, gated
// (R10) any write to caption status register acknowledges caption flag
// (R11) end of serial transfer sets transfer flag; gated by serial enable
// (R12) transfer flag cleared by status read then data access, reset, disable
// (R13) nine sources map to pending slots one to nine; display shares seven
// (R14) pending low register: slots six..one in bits 7..2, rest zero, read only
// (R15) pending high register: slots nine..seven in bits 2..0, read only
// (R16) a pending bit reads one exactly while its source requests
// (R17) fixed priority, lowest slot number wins
// (R18) cpu global mask blocks every maskable request
// (R19) pending bit is flag and enable; display slot ORs both sources
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module pis_top #(
  parameter int TICK_BASE_LOG2 = pis_pkg::TICK_BASE_LOG2,
  parameter int TICK_W = pis_pkg::TICK_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire pis_pkg::pis_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire pis_pkg::pis_src_t src,
  input wire logic cpu_irq_mask,
  output logic cpu_irq_req,
  output logic [3:0] cpu_irq_slot,
  output logic [7:0] serial_tx_data,
  output logic irq
);
  // refused at elaboration: rate 7 must still fit in the divider
  if (TICK_BASE_LOG2 < 1 || TICK_BASE_LOG2 + 7 > TICK_W) begin : g_bad_tick
    $error("tick divider too narrow for base and rate select");
  end

  logic wr;
  logic rd;
  logic [7:0] wd;
  logic [15:0] ad;
  assign wr = bus_req.wr;
  assign rd = bus_req.rd;
  assign wd = bus_req.wdata;
  assign ad = bus_req.addr;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // ---------------- timebase
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [2:0] tick_rate_select_reg;
  logic tick_irq_enable_reg;
  logic tick_flag_reg;
  logic tick_wrap;
  logic [TICK_W-1:0] tick_mask;
  assign tick_mask = (TICK_W'(1) << (TICK_BASE_LOG2 + int'(tick_rate_select_reg)))
    - TICK_W'(1);
  assign tick_wrap = ((tick_cnt_reg & tick_mask) == tick_mask);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tick_rate_select_reg <= 3'h0;
      tick_irq_enable_reg <= 1'b0;
    end else if (wr && hit(ad, pis_pkg::TICK_CTRL_ADDR)) begin
      tick_rate_select_reg <= wd[pis_pkg::TICK_RATE_LSB +: 3];
      tick_irq_enable_reg <= wd[pis_pkg::TICK_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tick_flag_reg <= 1'b0;
    end else if (tick_wrap) begin
      tick_flag_reg <= 1'b1; // (R1)
    end else if (wr && hit(ad, pis_pkg::TICK_CTRL_ADDR)
                 && wd[pis_pkg::TICK_ACK_BIT]) begin
      tick_flag_reg <= 1'b0; // (R2)
    end
  end

  // ---------------- timer wrap and channels
  logic [15:0] counter_prev_reg;
  logic counter_at_modulo_reg;
  logic wrap_flag_reg;
  logic wrap_irq_enable_reg;
  logic wrap_event;
  logic [1:0] channel_event_flag_reg;
  logic [1:0] channel_event_irq_enable_reg;

  // wrap is seen only when the previous sample sat on the modulo value
  assign wrap_event = counter_at_modulo_reg && (src.counter_value == 16'h0000)
    && (counter_prev_reg != 16'h0000); // (R3)

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      counter_prev_reg <= 16'h0000;
      counter_at_modulo_reg <= 1'b0;
    end else begin
      counter_prev_reg <= src.counter_value;
      counter_at_modulo_reg <= (src.counter_value == src.counter_modulo);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wrap_flag_reg <= 1'b0;
      wrap_irq_enable_reg <= 1'b0;
    end else begin
      if (wr && hit(ad, pis_pkg::WRAP_CTRL_ADDR)) begin
        wrap_irq_enable_reg <= wd[pis_pkg::IRQ_EN_BIT]; // (R4)
      end
      if (wrap_event) begin
        wrap_flag_reg <= 1'b1; // (R3)
      end else if (wr && hit(ad, pis_pkg::WRAP_CTRL_ADDR)
                   && !wd[pis_pkg::FLAG_BIT]) begin
        wrap_flag_reg <= 1'b0;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic ch_wr;
      assign ch_wr = wr && hit(ad, pis_pkg::CH0_CTRL_ADDR + 16'(ch));
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          channel_event_flag_reg[ch] <= 1'b0;
          channel_event_irq_enable_reg[ch] <= 1'b0;
        end else begin
          if (ch_wr) begin
            channel_event_irq_enable_reg[ch] <= wd[pis_pkg::IRQ_EN_BIT];
          end
          if (src.channel_event[ch]) begin
            channel_event_flag_reg[ch] <= 1'b1; // (R5)
          end else if (ch_wr && !wd[pis_pkg::FLAG_BIT]) begin
            channel_event_flag_reg[ch] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ---------------- display
  logic [7:0] display_target_line_reg;
  logic line_match_irq_enable_reg;
  logic frame_sync_irq_enable_reg;
  logic line_match_flag_reg;
  logic frame_sync_flag_reg;
  logic line_equal_reg;
  logic frame_sync_prev_reg;
  logic line_event;
  logic sync_event;
  logic disp_ack;
  // flag on entering equality, so a line held still sets it once
  assign line_event = (src.scan_line == display_target_line_reg)
    && !line_equal_reg; // (R6)
  assign sync_event = src.frame_sync && !frame_sync_prev_reg; // (R7)
  assign disp_ack = wr && hit(ad, pis_pkg::DISP_STAT_ADDR); // (R8)

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      line_equal_reg <= 1'b0;
      frame_sync_prev_reg <= 1'b0;
    end else begin
      line_equal_reg <= (src.scan_line == display_target_line_reg);
      frame_sync_prev_reg <= src.frame_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      display_target_line_reg <= pis_pkg::RESET_BYTE;
      line_match_irq_enable_reg <= 1'b0;
      frame_sync_irq_enable_reg <= 1'b0;
    end else begin
      if (wr && hit(ad, pis_pkg::DISP_LINE_ADDR)) begin
        display_target_line_reg <= wd;
      end
      if (wr && hit(ad, pis_pkg::DISP_EN_ADDR)) begin
        line_match_irq_enable_reg <= wd[pis_pkg::LINE_BIT];
        frame_sync_irq_enable_reg <= wd[pis_pkg::SYNC_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      line_match_flag_reg <= 1'b0;
      frame_sync_flag_reg <= 1'b0;
    end else begin
      line_match_flag_reg <= line_event || (line_match_flag_reg && !disp_ack);
      frame_sync_flag_reg <= sync_event || (frame_sync_flag_reg && !disp_ack);
    end
  end

  // ---------------- caption slicer
  logic [15:0] cap_shift_reg;
  logic [3:0] cap_count_reg;
  logic [7:0] caption_char_first_reg;
  logic [7:0] caption_char_second_reg;
  logic caption_ready_flag_reg;
  logic caption_irq_enable_reg;
  logic cap_done;
  assign cap_done = src.caption_bit_valid && (cap_count_reg == 4'(15));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cap_shift_reg <= 16'h0000;
      cap_count_reg <= 4'h0;
      caption_char_first_reg <= pis_pkg::RESET_BYTE;
      caption_char_second_reg <= pis_pkg::RESET_BYTE;
    end else if (src.caption_bit_valid) begin
      // first bit received lands in bit 0 of the first character
      cap_shift_reg <= {src.caption_bit, cap_shift_reg[15:1]};
      cap_count_reg <= cap_count_reg + 4'h1;
      if (cap_done) begin
        caption_char_first_reg <= cap_shift_reg[8:1];
        caption_char_second_reg <= {src.caption_bit, cap_shift_reg[15:9]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      caption_irq_enable_reg <= 1'b0;
    end else if (wr && hit(ad, pis_pkg::CAP_CTRL_ADDR)) begin
      caption_irq_enable_reg <= wd[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      caption_ready_flag_reg <= 1'b0;
    end else if (cap_done) begin
      caption_ready_flag_reg <= 1'b1; // (R9)
    end else if (wr && hit(ad, pis_pkg::CAP_STAT_ADDR)) begin
      caption_ready_flag_reg <= 1'b0; // (R10)
    end
  end

  // ---------------- serial
  logic transfer_done_flag_reg;
  logic transfer_irq_enable_reg;
  logic serial_on_reg;
  logic ser_armed_reg;
  logic [7:0] serial_data_reg;
  logic ser_data_access;
  logic ser_off_write;
  assign ser_data_access = (wr || rd) && hit(ad, pis_pkg::SER_DATA_ADDR);
  assign ser_off_write = wr && hit(ad, pis_pkg::SER_CTRL_ADDR)
    && !wd[pis_pkg::SER_ON_BIT];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      transfer_irq_enable_reg <= 1'b0;
      serial_on_reg <= 1'b0;
      serial_tx_data <= pis_pkg::RESET_BYTE;
      serial_data_reg <= pis_pkg::RESET_BYTE;
    end else begin
      if (wr && hit(ad, pis_pkg::SER_CTRL_ADDR)) begin
        transfer_irq_enable_reg <= wd[pis_pkg::SER_IRQ_EN_BIT];
        serial_on_reg <= wd[pis_pkg::SER_ON_BIT];
      end
      if (wr && hit(ad, pis_pkg::SER_DATA_ADDR)) begin
        serial_tx_data <= wd;
      end
      if (src.transfer_done) begin
        serial_data_reg <= src.serial_rx_data;
      end
    end
  end

  // a status read with the flag up arms the clear; the data access fires it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      transfer_done_flag_reg <= 1'b0; // (R12)
      ser_armed_reg <= 1'b0;
    end else begin
      if (src.transfer_done) begin
        transfer_done_flag_reg <= 1'b1; // (R11)
      end else if ((ser_armed_reg && ser_data_access) || ser_off_write) begin
        transfer_done_flag_reg <= 1'b0; // (R12)
      end
      if (rd && hit(ad, pis_pkg::SER_STAT_ADDR) && transfer_done_flag_reg) begin
        ser_armed_reg <= 1'b1;
      end else if (ser_data_access || ser_off_write) begin
        ser_armed_reg <= 1'b0;
      end
    end
  end

  // ---------------- pending slots, priority, cpu request
  logic [pis_pkg::NUM_SLOTS:1] pend;
  assign pend[1] = src.ext_flag && src.ext_irq_enable; // (R13)
  assign pend[2] = src.pll_flag && src.pll_irq_enable;
  assign pend[3] = tick_flag_reg && tick_irq_enable_reg; // (R1)
  assign pend[4] = channel_event_flag_reg[0] && channel_event_irq_enable_reg[0];
  assign pend[5] = channel_event_flag_reg[1]
    && channel_event_irq_enable_reg[1]; // (R5)
  assign pend[6] = wrap_flag_reg && wrap_irq_enable_reg; // (R4)
  assign pend[7] = (line_match_flag_reg && line_match_irq_enable_reg)
    || (frame_sync_flag_reg && frame_sync_irq_enable_reg); // (R19)
  assign pend[8] = caption_ready_flag_reg && caption_irq_enable_reg; // (R9)
  assign pend[9] = transfer_done_flag_reg && transfer_irq_enable_reg; // (R11)

  logic [3:0] slot_next;
  always_comb begin
    slot_next = 4'h0;
    for (int i = pis_pkg::NUM_SLOTS; i >= 1; i--) begin
      if (pend[i]) begin
        slot_next = 4'(i); // (R17)
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cpu_irq_slot <= 4'h0;
    end else begin
      cpu_irq_slot <= slot_next;
    end
  end

  assign cpu_irq_req = (|pend) && !cpu_irq_mask; // (R18)

  // ---------------- sticky event status with mask, cleared by read
  logic [7:0] evt_stat_reg;
  logic [7:0] evt_mask_reg;
  logic [7:0] evt_in;
  assign evt_in = {src.transfer_done, cap_done, sync_event, line_event,
    src.channel_event[1], src.channel_event[0], wrap_event, tick_wrap};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      evt_stat_reg <= pis_pkg::RESET_BYTE;
    end else if (rd && hit(ad, pis_pkg::EVT_STAT_ADDR)) begin
      evt_stat_reg <= evt_in; // set wins over the read clear
    end else begin
      evt_stat_reg <= evt_stat_reg | evt_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      evt_mask_reg <= pis_pkg::RESET_BYTE;
    end else if (wr && hit(ad, pis_pkg::EVT_MASK_ADDR)) begin
      evt_mask_reg <= wd;
    end
  end

  assign irq = |(evt_stat_reg & evt_mask_reg);

  // ---------------- read mux
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    unique case (ad)
      pis_pkg::PEND_LOW_ADDR: rdata_next = {pend[6:1], 2'b00}; // (R14) (R16)
      pis_pkg::PEND_HIGH_ADDR: rdata_next = {5'h00, pend[9:7]}; // (R15)
      pis_pkg::TICK_CTRL_ADDR: rdata_next = {tick_flag_reg, 2'b00,
        tick_rate_select_reg, 1'b0, tick_irq_enable_reg};
      pis_pkg::WRAP_CTRL_ADDR: rdata_next = {wrap_flag_reg,
        wrap_irq_enable_reg, 6'h00};
      pis_pkg::CH0_CTRL_ADDR: rdata_next = {channel_event_flag_reg[0],
        channel_event_irq_enable_reg[0], 6'h00};
      pis_pkg::CH1_CTRL_ADDR: rdata_next = {channel_event_flag_reg[1],
        channel_event_irq_enable_reg[1], 6'h00};
      pis_pkg::DISP_STAT_ADDR: rdata_next = {6'h00, frame_sync_flag_reg,
        line_match_flag_reg};
      pis_pkg::DISP_EN_ADDR: rdata_next = {6'h00, frame_sync_irq_enable_reg,
        line_match_irq_enable_reg};
      pis_pkg::DISP_LINE_ADDR: rdata_next = display_target_line_reg;
      pis_pkg::CAP_STAT_ADDR: rdata_next = {7'h00, caption_ready_flag_reg};
      pis_pkg::CAP_CTRL_ADDR: rdata_next = {7'h00, caption_irq_enable_reg};
      pis_pkg::CAP_CHAR1_ADDR: rdata_next = caption_char_first_reg;
      pis_pkg::CAP_CHAR2_ADDR: rdata_next = caption_char_second_reg;
      pis_pkg::SER_STAT_ADDR: rdata_next = {7'h00, transfer_done_flag_reg};
      pis_pkg::SER_CTRL_ADDR: rdata_next = {6'h00, serial_on_reg,
        transfer_irq_enable_reg};
      pis_pkg::SER_DATA_ADDR: rdata_next = serial_data_reg;
      pis_pkg::EVT_STAT_ADDR: rdata_next = evt_stat_reg;
      pis_pkg::EVT_MASK_ADDR: rdata_next = evt_mask_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rd ? rdata_next : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** testbench/pis_props.sv ***
// checker: port relations of the interrupt status block
`timescale 1ns/1ns
`default_nettype none
module pis_props #(
  parameter int TICK_BASE_LOG2 = pis_pkg::TICK_BASE_LOG2,
  parameter int TICK_W = pis_pkg::TICK_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire pis_pkg::pis_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire pis_pkg::pis_src_t src,
  input wire logic cpu_irq_mask,
  input wire logic cpu_irq_req,
  input wire logic [3:0] cpu_irq_slot,
  input wire logic [7:0] serial_tx_data,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic ext_p;
  logic pll_p;
  logic rd_lo;
  logic rd_hi;
  assign ext_p = src.ext_flag & src.ext_irq_enable;
  assign pll_p = src.pll_flag & src.pll_irq_enable;
  assign rd_lo = bus_req.rd && bus_req.addr == pis_pkg::PEND_LOW_ADDR;
  assign rd_hi = bus_req.rd && bus_req.addr == pis_pkg::PEND_HIGH_ADDR;
  property p_mask_blocks;
    cpu_irq_mask |-> !cpu_irq_req;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("request under global mask");
  property p_ext_req;
    ext_p && !cpu_irq_mask |-> cpu_irq_req;
  endproperty
  a_ext_req: assert property (p_ext_req)
    else $error("pin request missing");
  property p_slot_ext;
    ext_p |=> cpu_irq_slot == 4'h1;
  endproperty
  a_slot_ext: assert property (p_slot_ext)
    else $error("pin slot not first");
  property p_slot_pll;
    pll_p && !ext_p |=> cpu_irq_slot == 4'h2;
  endproperty
  a_slot_pll: assert property (p_slot_pll)
    else $error("pll slot wrong");
  property p_low_zero;
    rd_lo |=> bus_rdata[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("low status bits 1:0 not zero");
  property p_high_zero;
    rd_hi |=> bus_rdata[7:3] == 5'h00;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("high status bits 7:3 not zero");
  property p_ext_bit;
    rd_lo && ext_p |=> bus_rdata[2];
  endproperty
  a_ext_bit: assert property (p_ext_bit)
    else $error("pin pending bit reads zero");
  property p_slot_none;
    !cpu_irq_mask && !cpu_irq_req |=> cpu_irq_slot == 4'h0;
  endproperty
  a_slot_none: assert property (p_slot_none)
    else $error("slot shown with nothing pending");
  property p_slot_some;
    !cpu_irq_mask && cpu_irq_req |=> cpu_irq_slot inside {[4'h1:4'h9]};
  endproperty
  a_slot_some: assert property (p_slot_some)
    else $error("slot out of range while pending");
  c_ext: cover property (rd_lo && ext_p);
  c_pll: cover property (cpu_irq_slot == 4'h2);
  c_ser: cover property (bus_req.rd && bus_req.addr == pis_pkg::SER_DATA_ADDR);
  c_irq: cover property (irq);
endmodule
bind pis_top pis_props #(
  .TICK_BASE_LOG2(TICK_BASE_LOG2),
  .TICK_W(TICK_W)
) pis_props_i (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .src(src), .cpu_irq_mask(cpu_irq_mask),
  .cpu_irq_req(cpu_irq_req), .cpu_irq_slot(cpu_irq_slot),
  .serial_tx_data(serial_tx_data), .irq(irq));
`default_nettype wire

// *** testbench/pis_src_model.sv ***
// peripheral source model: flags, counters and event pulses
`timescale 1ns/1ns
`default_nettype none
module pis_src_model (
  input wire logic clk_sys,
  output var pis_pkg::pis_src_t src
);
  // idle counter sits off the modulo so no stray wrap is seen
  initial begin
    src = '0;
    src.counter_modulo = 16'h0010;
    src.counter_value = 16'h0001;
  end
  task automatic levels(input logic ef, ee, pf, pe);
    @(posedge clk_sys);
    src.ext_flag <= ef;
    src.ext_irq_enable <= ee;
    src.pll_flag <= pf;
    src.pll_irq_enable <= pe;
  endtask
  task automatic wrap(input logic [15:0] m);
    @(posedge clk_sys);
    src.counter_modulo <= m;
    src.counter_value <= m;
    @(posedge clk_sys);
    src.counter_value <= 16'h0000;
    @(posedge clk_sys);
    src.counter_value <= 16'h0001;
  endtask
  task automatic chan(input int ch);
    @(posedge clk_sys);
    src.channel_event[ch] <= 1'b1;
    @(posedge clk_sys);
    src.channel_event <= 2'b00;
  endtask
  task automatic line(input logic [7:0] l);
    @(posedge clk_sys);
    src.scan_line <= l;
  endtask
  task automatic sync(input logic s);
    @(posedge clk_sys);
    src.frame_sync <= s;
  endtask
  // bit 0 of the first char goes out first
  task automatic cap(input logic [15:0] v);
    for (int i = 0; i < pis_pkg::CAP_BITS; i++) begin
      @(posedge clk_sys);
      src.caption_bit_valid <= 1'b1;
      src.caption_bit <= v[i];
    end
    @(posedge clk_sys);
    src.caption_bit_valid <= 1'b0;
    src.caption_bit <= ~v[15];
  endtask
  // byte is only good beside the done pulse, so it is scrambled after
  task automatic xfer(input logic [7:0] b);
    @(posedge clk_sys);
    src.serial_rx_data <= b;
    src.transfer_done <= 1'b1;
    @(posedge clk_sys);
    src.transfer_done <= 1'b0;
    src.serial_rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench: bus tasks and register scenarios for the interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys;
  logic rstn;
  pis_pkg::pis_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  pis_pkg::pis_src_t src;
  logic cpu_irq_mask;
  logic cpu_irq_req;
  logic [3:0] cpu_irq_slot;
  logic [7:0] serial_tx_data;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] d;
  // short tick base keeps the tick period within a few hundred clocks
  pis_top #(.TICK_BASE_LOG2(1)) pis_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .src(src), .cpu_irq_mask(cpu_irq_mask),
    .cpu_irq_req(cpu_irq_req), .cpu_irq_slot(cpu_irq_slot),
    .serial_tx_data(serial_tx_data), .irq(irq));
  pis_src_model pis_src_model_i (.clk_sys(clk_sys), .src(src));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    rstn = 1'b0;
    bus_req = '0;
    cpu_irq_mask = 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    rc(pis_pkg::PEND_LOW_ADDR, 8'h00);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    wr(pis_pkg::PEND_LOW_ADDR, 8'hff);
    wr(pis_pkg::PEND_HIGH_ADDR, 8'hff);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h00);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    rc(16'hfe3f, 8'h00);
    pis_src_model_i.levels(1'b1, 1'b1, 1'b1, 1'b1);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h0c);
    chk("slot", 8'h01, {4'h0, cpu_irq_slot});
    chk("req", 8'h01, {7'h00, cpu_irq_req});
    @(posedge clk_sys);
    cpu_irq_mask <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("req", 8'h00, {7'h00, cpu_irq_req});
    @(posedge clk_sys);
    cpu_irq_mask <= 1'b0;
    pis_src_model_i.levels(1'b1, 1'b0, 1'b1, 1'b1);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h08);
    chk("slot", 8'h02, {4'h0, cpu_irq_slot});
    pis_src_model_i.levels(1'b0, 1'b0, 1'b0, 1'b0);
    // rate 7 gives one tick wrap per 256 clocks
    wr(pis_pkg::TICK_CTRL_ADDR, 8'h1c);
    repeat (300) @(posedge clk_sys);
    rc(pis_pkg::TICK_CTRL_ADDR, 8'h9c);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h00);
    wr(pis_pkg::TICK_CTRL_ADDR, 8'h1d);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h10);
    wr(pis_pkg::TICK_CTRL_ADDR, 8'h1f);
    rc(pis_pkg::TICK_CTRL_ADDR, 8'h1d);
    wr(pis_pkg::TICK_CTRL_ADDR, 8'h1c);
    wr(pis_pkg::WRAP_CTRL_ADDR, 8'h40);
    pis_src_model_i.wrap(16'h0123);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h80);
    rc(pis_pkg::WRAP_CTRL_ADDR, 8'hc0);
    wr(pis_pkg::WRAP_CTRL_ADDR, 8'h40);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h00);
    wr(pis_pkg::CH0_CTRL_ADDR, 8'h40);
    wr(pis_pkg::CH1_CTRL_ADDR, 8'h40);
    pis_src_model_i.chan(0);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h20);
    chk("irq", 8'h00, {7'h00, irq});
    wr(pis_pkg::EVT_MASK_ADDR, 8'h04);
    chk("irq", 8'h01, {7'h00, irq});
    rd(pis_pkg::EVT_STAT_ADDR, d);
    chk("evt", 8'h04, d & 8'h04);
    chk("irq", 8'h00, {7'h00, irq});
    pis_src_model_i.chan(1);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h60);
    chk("slot", 8'h04, {4'h0, cpu_irq_slot});
    wr(pis_pkg::CH0_CTRL_ADDR, 8'h40);
    wr(pis_pkg::CH1_CTRL_ADDR, 8'h40);
    rc(pis_pkg::PEND_LOW_ADDR, 8'h00);
    wr(pis_pkg::DISP_LINE_ADDR, 8'h21);
    wr(pis_pkg::DISP_EN_ADDR, 8'h03);
    // line 0 matched the reset target, so start from a clean flag
    wr(pis_pkg::DISP_STAT_ADDR, 8'h00);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    pis_src_model_i.line(8'h21);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h01);
    pis_src_model_i.line(8'h22);
    wr(pis_pkg::DISP_STAT_ADDR, 8'h00);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    pis_src_model_i.sync(1'b1);
    rc(pis_pkg::DISP_STAT_ADDR, 8'h02);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h01);
    pis_src_model_i.sync(1'b0);
    wr(pis_pkg::DISP_STAT_ADDR, 8'h5a);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    wr(pis_pkg::CAP_CTRL_ADDR, 8'h01);
    pis_src_model_i.cap(16'ha5c3);
    rc(pis_pkg::CAP_CHAR1_ADDR, 8'hc3);
    rc(pis_pkg::CAP_CHAR2_ADDR, 8'ha5);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h02);
    wr(pis_pkg::CAP_STAT_ADDR, 8'hff);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h00);
    wr(pis_pkg::SER_CTRL_ADDR, 8'h03);
    pis_src_model_i.xfer(8'h5e);
    rc(pis_pkg::PEND_HIGH_ADDR, 8'h04);
    rc(pis_pkg::SER_STAT_ADDR, 8'h01);
    rc(pis_pkg::SER_DATA_ADDR, 8'h5e);
    rc(pis_pkg::SER_STAT_ADDR, 8'h00);
    wr(pis_pkg::SER_DATA_ADDR, 8'h77);
    chk("tx", 8'h77, serial_tx_data);
    pis_src_model_i.xfer(8'h3c);
    wr(pis_pkg::SER_CTRL_ADDR, 8'h01);
    rc(pis_pkg::SER_STAT_ADDR, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
